//--- verilog/acc_top.sv
// Control logic around an analog comparator, AHB-Lite slave.
// Assumes the analog core and timer capture run beside it on clk.
//
// How it works
// - Raw high means positive above negative
// - Mux on, converter off: channel 0-7 negative
// - Otherwise dedicated negative pin is used
// - Power-off bit 7 gates comparator power
// - Bandgap bit swaps positive input for reference
// - Result passes two-flop synchroniser first
// - Trigger on rise, fall or toggle
// - Flag set on transition picked by mode
// - Request needs flag, enable, global enable
// - Vector taken clears the flag
// - Writing one clears flag, zero keeps
// - Capture bit routes result to timer
// - Capture bit clear blocks timer path
// - Mode 00 toggle, 01 none, 10 fall, 11 rise
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module acc_top (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Analog comparator core
	input wire logic cmp_raw,
	output logic cmp_power_off,
	output logic cmp_bandgap_select,
	output logic cmp_neg_use_pin,
	output logic [2:0] cmp_neg_channel,
	// Processor side
	input wire logic cpu_global_irq_enable,
	input wire logic cpu_vector_taken,
	output logic cmp_irq_req,
	output logic irq,
	// Timer capture front end
	output logic timer_capture_in
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] ctrl_b;
		logic power_off;
		logic bandgap;
		logic flag;
		logic irq_en;
		logic cap_route;
		logic [1:0] mode;
		logic [4:0] chan;
		logic conv_en;
		logic [1:0] irq_status;
		logic [1:0] irq_enable;
		logic prev;
		logic prev_valid;
		logic wr_pend;
		logic [7:0] wr_idx;
		logic [31:0] rdata;
		logic ready;
		logic neg_use_pin;
		logic [2:0] neg_chan;
		logic capture;
		logic cmp_irq;
		logic irq;
	} acc_state_s;

	acc_state_s st;
	acc_state_s next_st;
	logic cur;
	logic ev_rise;
	logic ev_fall;
	logic ev_tog;
	logic sel_event;
	logic take;
	logic [7:0] idx;
	logic [7:0] wbyte;
	logic wr_csr;
	logic [7:0] csr_view;

	// ----------------------------------------
	// Synchroniser
	// ----------------------------------------
	// Raw is high when positive input wins; taken as is.
	acc_sync #(
		.STAGES(acc_pkg::ACC_SYNC_STAGES)
	) u_sync (
		.clk(clk),
		.srst(srst),
		.din(cmp_raw),
		.dout(cur)
	);

	// ----------------------------------------
	// Event detection
	// ----------------------------------------
	always_comb
	begin
		// First sample after reset is not an edge
		ev_rise = st.prev_valid && cur && !st.prev;
		ev_fall = st.prev_valid && !cur && st.prev;
		ev_tog = ev_rise || ev_fall;
		case (st.mode)
			acc_pkg::ACC_MODE_TOGGLE: sel_event = ev_tog;
			acc_pkg::ACC_MODE_FALL: sel_event = ev_fall;
			acc_pkg::ACC_MODE_RISE: sel_event = ev_rise;
			default: sel_event = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	always_comb
	begin
		take = hsel && htrans[1] && hready;
		idx = haddr[9:2];
		wbyte = hwdata[7:0];
		wr_csr = st.wr_pend && (st.wr_idx == acc_pkg::ACC_IDX_CSR);
		csr_view = {st.power_off, st.bandgap, cur, st.flag,
			st.irq_en, st.cap_route, st.mode};
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		next_st = st;
		next_st.ready = 1'b1;
		next_st.prev = cur;
		next_st.prev_valid = 1'b1;
		// Data phase: write lands here
		if (st.wr_pend)
		begin
			case (st.wr_idx)
				acc_pkg::ACC_IDX_CTRL_B:
					next_st.ctrl_b = wbyte & acc_pkg::ACC_CTRLB_MASK;
				acc_pkg::ACC_IDX_CSR:
				begin
					next_st.power_off = wbyte[acc_pkg::ACC_CSR_POWER_OFF];
					next_st.bandgap = wbyte[acc_pkg::ACC_CSR_BANDGAP];
					next_st.irq_en = wbyte[acc_pkg::ACC_CSR_IRQ_EN];
					next_st.cap_route = wbyte[acc_pkg::ACC_CSR_CAPTURE];
					next_st.mode = wbyte[acc_pkg::ACC_CSR_MODE_LO +: 2];
					if (wbyte[acc_pkg::ACC_CSR_FLAG])
						next_st.flag = 1'b0;
				end
				acc_pkg::ACC_IDX_MUX:
					next_st.chan = wbyte[4:0];
				acc_pkg::ACC_IDX_CTRL_A:
					next_st.conv_en = wbyte[acc_pkg::ACC_CTRLA_CONV_EN];
				acc_pkg::ACC_IDX_IRQ_ENABLE:
					next_st.irq_enable = wbyte[1:0];
				acc_pkg::ACC_IDX_IRQ_CLEAR:
					next_st.irq_status = st.irq_status & ~wbyte[1:0];
				default:
					next_st.chan = next_st.chan;
			endcase
		end
		if (cpu_vector_taken)
			next_st.flag = 1'b0;
		// Set wins over any clear in the same cycle
		if (sel_event)
			next_st.flag = 1'b1;
		if (sel_event)
			next_st.irq_status[acc_pkg::ACC_ST_EVENT] = 1'b1;
		if (ev_tog)
			next_st.irq_status[acc_pkg::ACC_ST_TOGGLE] = 1'b1;
		// Address phase
		next_st.wr_pend = take && hwrite;
		next_st.wr_idx = idx;
		next_st.rdata = '0;
		if (take && !hwrite)
		begin
			case (idx)
				acc_pkg::ACC_IDX_CTRL_B: next_st.rdata = {24'h000000, st.ctrl_b};
				acc_pkg::ACC_IDX_CSR: next_st.rdata = {24'h000000, csr_view};
				acc_pkg::ACC_IDX_MUX: next_st.rdata = {27'h0000000, st.chan};
				acc_pkg::ACC_IDX_CTRL_A: next_st.rdata = {24'h000000, st.conv_en, 7'h00};
				acc_pkg::ACC_IDX_IRQ_STATUS: next_st.rdata = {30'h00000000, st.irq_status};
				acc_pkg::ACC_IDX_IRQ_ENABLE: next_st.rdata = {30'h00000000, st.irq_enable};
				default: next_st.rdata = '0;
			endcase
		end
		// Negative input select, from settled registers
		if (st.ctrl_b[acc_pkg::ACC_CTRLB_MUX_EN] && !st.conv_en
			&& (st.chan <= acc_pkg::ACC_CHAN_LAST))
			next_st.neg_use_pin = 1'b0;
		else
			next_st.neg_use_pin = 1'b1;
		next_st.neg_chan = st.chan[2:0];
		// Gated so no path exists with routing off
		next_st.capture = st.cap_route && cur;
		next_st.cmp_irq = st.flag && st.irq_en && cpu_global_irq_enable;
		next_st.irq = |(next_st.irq_status & next_st.irq_enable);
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st <= '0;
			st.ready <= 1'b1;
			st.neg_use_pin <= 1'b1;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign hreadyout = st.ready;
	assign hresp = 1'b0;
	assign hrdata = st.rdata;
	assign cmp_power_off = st.power_off;
	assign cmp_bandgap_select = st.bandgap;
	assign cmp_neg_use_pin = st.neg_use_pin;
	assign cmp_neg_channel = st.neg_chan;
	assign cmp_irq_req = st.cmp_irq;
	assign irq = st.irq;
	assign timer_capture_in = st.capture;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	result_sync_a: assert property (@(posedge clk) disable iff (srst)
		$past(srst, 2) == 1'b0 |-> cur == $past(cmp_raw, 2))
		else $error("result not two cycles behind raw");

	neg_pin_a: assert property (@(posedge clk) disable iff (srst)
		(!st.ctrl_b[acc_pkg::ACC_CTRLB_MUX_EN] || st.conv_en) |=> cmp_neg_use_pin)
		else $error("dedicated negative pin not selected");

	neg_chan_a: assert property (@(posedge clk) disable iff (srst)
		(st.ctrl_b[acc_pkg::ACC_CTRLB_MUX_EN] && !st.conv_en && st.chan <= 5'h07)
		|=> (!cmp_neg_use_pin && cmp_neg_channel == $past(st.chan[2:0])))
		else $error("converter channel not routed");

	power_bit_a: assert property (@(posedge clk) disable iff (srst)
		wr_csr |=> cmp_power_off == $past(hwdata[7]))
		else $error("power off bit not applied");

	bandgap_bit_a: assert property (@(posedge clk) disable iff (srst)
		wr_csr |=> cmp_bandgap_select == $past(hwdata[6]))
		else $error("bandgap select not applied");

	rise_flag_a: assert property (@(posedge clk) disable iff (srst)
		(st.mode == acc_pkg::ACC_MODE_RISE && ev_rise) |=> st.flag)
		else $error("rising event lost");

	fall_only_a: assert property (@(posedge clk) disable iff (srst)
		(st.mode == acc_pkg::ACC_MODE_FALL && ev_rise) |=> !(st.flag && !$past(st.flag)))
		else $error("rising edge set flag in fall mode");

	reserved_mode_a: assert property (@(posedge clk) disable iff (srst)
		st.mode == acc_pkg::ACC_MODE_RESERVED |=> !(st.flag && !$past(st.flag)))
		else $error("flag set in reserved mode");

	irq_req_a: assert property (@(posedge clk) disable iff (srst)
		cmp_irq_req |-> $past(st.flag && st.irq_en && cpu_global_irq_enable))
		else $error("request without its three conditions");

	vector_clear_a: assert property (@(posedge clk) disable iff (srst)
		(cpu_vector_taken && !sel_event) |=> !st.flag)
		else $error("vector did not clear flag");

	flag_w1c_a: assert property (@(posedge clk) disable iff (srst)
		(wr_csr && !hwdata[4] && st.flag && !cpu_vector_taken) |=> st.flag)
		else $error("writing zero cleared flag");

	set_wins_a: assert property (@(posedge clk) disable iff (srst)
		sel_event |=> st.flag)
		else $error("selected event did not set flag");

	fall_flag_a: assert property (@(posedge clk) disable iff (srst)
		(st.mode == acc_pkg::ACC_MODE_FALL && ev_fall) |=> st.flag)
		else $error("falling event lost");

	capture_route_a: assert property (@(posedge clk) disable iff (srst)
		st.cap_route |=> timer_capture_in == $past(cur))
		else $error("result not routed to capture");

	capture_gate_a: assert property (@(posedge clk) disable iff (srst)
		!st.cap_route |=> !timer_capture_in)
		else $error("capture path open while disabled");

	toggle_cover_c: cover property (@(posedge clk) disable iff (srst)
		st.mode == acc_pkg::ACC_MODE_TOGGLE && ev_tog ##1 cmp_irq_req);
	capture_cover_c: cover property (@(posedge clk) disable iff (srst)
		st.cap_route && ev_rise ##1 timer_capture_in);
	mux_cover_c: cover property (@(posedge clk) disable iff (srst)
		!cmp_neg_use_pin ##1 cmp_neg_use_pin);
	vector_cover_c: cover property (@(posedge clk) disable iff (srst)
		st.flag && cpu_vector_taken ##1 !st.flag);
endmodule
`default_nettype wire

//--- verilog/acc_pkg.sv
// Constants for the comparator control block.
// Assumes a 32-bit AHB-Lite bus with one word per register.
`default_nettype none
package acc_pkg;
	// ----------------------------------------
	// Register indices, byte address = 4 * index
	// ----------------------------------------
	localparam logic [7:0] ACC_IDX_CTRL_B = 8'h03;
	localparam logic [7:0] ACC_IDX_CSR = 8'h08;
	localparam logic [7:0] ACC_IDX_MUX = 8'h10;
	localparam logic [7:0] ACC_IDX_CTRL_A = 8'h11;
	localparam logic [7:0] ACC_IDX_IRQ_STATUS = 8'h20;
	localparam logic [7:0] ACC_IDX_IRQ_ENABLE = 8'h21;
	localparam logic [7:0] ACC_IDX_IRQ_CLEAR = 8'h22;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int ACC_CSR_POWER_OFF = 7;
	localparam int ACC_CSR_BANDGAP = 6;
	localparam int ACC_CSR_RESULT = 5;
	localparam int ACC_CSR_FLAG = 4;
	localparam int ACC_CSR_IRQ_EN = 3;
	localparam int ACC_CSR_CAPTURE = 2;
	localparam int ACC_CSR_MODE_LO = 0;
	localparam int ACC_CTRLB_MUX_EN = 6;
	localparam int ACC_CTRLA_CONV_EN = 7;
	localparam int ACC_ST_EVENT = 0;
	localparam int ACC_ST_TOGGLE = 1;
	// Writable bits of converter_control_b: 7, 6, 4, 2..0
	localparam logic [7:0] ACC_CTRLB_MASK = 8'hd7;
	// ----------------------------------------
	// Reset values and codes
	// ----------------------------------------
	localparam logic [7:0] ACC_CTRLB_RESET = 8'h00;
	localparam logic [7:0] ACC_CSR_RESET = 8'h00;
	localparam logic [1:0] ACC_MODE_TOGGLE = 2'h0;
	localparam logic [1:0] ACC_MODE_RESERVED = 2'h1;
	localparam logic [1:0] ACC_MODE_FALL = 2'h2;
	localparam logic [1:0] ACC_MODE_RISE = 2'h3;
	localparam logic [4:0] ACC_CHAN_LAST = 5'h07;
	localparam int ACC_SYNC_STAGES = 2;
endpackage
`default_nettype wire

//--- verilog/acc_sync.sv
// Level synchroniser for the raw comparator output.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module acc_sync #(
	parameter int STAGES = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Level in and out
	input wire logic din,
	output logic dout
);
	typedef struct packed {
		logic [STAGES-1:0] chain;
	} acc_sync_s;

	acc_sync_s st;
	acc_sync_s next_st;

	// One stage would let metastability reach the edge detector
	if (STAGES < 2)
	begin : g_bad_stages
		$error("acc_sync needs at least two stages");
	end

	// Only the last stage is read
	always_comb
	begin
		next_st.chain = {st.chain[STAGES-2:0], din};
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			st <= '0;
		else
			st <= next_st;
	end

	assign dout = st.chain[STAGES-1];
endmodule
`default_nettype wire

//--- verification/acc_cmp_model.sv
// Analog comparator core model with input selection.
// Assumes millivolt levels driven by the bench.
`timescale 1ns/1ps
`default_nettype none
module acc_cmp_model #(
	parameter logic [11:0] BANDGAP_MV = 12'h44c
) (
	// Analog levels
	input wire logic [11:0] pos_mv,
	input wire logic [11:0] neg_mv,
	// Controls from the block
	input wire logic power_off,
	input wire logic bandgap_select,
	input wire logic neg_use_pin,
	input wire logic [2:0] neg_channel,
	// Result
	output logic raw
);
	logic [11:0] p;
	logic [11:0] n;
	assign p = bandgap_select ? BANDGAP_MV : pos_mv;
	// Converter pin k sits at 100k + 50 mV
	assign n = neg_use_pin ? neg_mv : 12'h064 * {9'h0, neg_channel} + 12'h032;
	// Unpowered core reads low, so no stale level leaks through
	assign raw = !power_off && (p > n);
endmodule
`default_nettype wire

//--- verification/analog_comparator_control_tb.sv
// Self-checking bench for the comparator control block.
// Assumes one 200 MHz clock and a zero-wait AHB-Lite slave.
`timescale 1ns/1ps
`default_nettype none
module analog_comparator_control_tb;
	typedef struct packed {logic [7:0] cb; logic [7:0] ca; logic [7:0] mx; logic pin; logic [2:0] ch;} acc_row_s;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic hsel = 1'b0, hwrite = 1'b0, gie = 1'b0, vtk = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
	logic hreadyout, hresp, raw, pwr, bgs, pin, req, irq, cap;
	logic [2:0] chan;
	logic [11:0] pos = 12'h1f4;
	logic [1:0] m;
	int error_cnt = 0;
	int comparisons = 0;
	acc_row_s rows [5] = '{'{8'h00, 8'h00, 8'h03, 1'b1, 3'h0}, '{8'h40, 8'h80, 8'h03, 1'b1, 3'h0},
		'{8'h40, 8'h00, 8'h00, 1'b0, 3'h0}, '{8'h40, 8'h00, 8'h07, 1'b0, 3'h7}, '{8'h40, 8'h00, 8'h08, 1'b1, 3'h0}};
	always #2.5 clk = ~clk;
	acc_top i_acc_top (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.cmp_raw(raw), .cmp_power_off(pwr), .cmp_bandgap_select(bgs), .cmp_neg_use_pin(pin),
		.cmp_neg_channel(chan), .cpu_global_irq_enable(gie), .cpu_vector_taken(vtk), .cmp_irq_req(req),
		.irq(irq), .timer_capture_in(cap));
	acc_cmp_model i_acc_cmp_model (.pos_mv(pos), .neg_mv(12'h3e8), .power_off(pwr), .bandgap_select(bgs),
		.neg_use_pin(pin), .neg_channel(chan), .raw(raw));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic report_and_stop();
		if (error_cnt == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask
	// Bounded wait for hready at a rising edge
	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge clk);
		while (hreadyout !== 1'b1)
		begin
			n++;
			if (n > 20)
			begin
				error_cnt++;
				report_and_stop();
			end
			@(posedge clk);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] e);
		xfer(1'b0, idx, 32'h0);
		chk(nm, e, rd);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial
	begin
		tick(12);
		srst <= 1'b0;
		rdc("csr reset", acc_pkg::ACC_IDX_CSR, {24'h0, acc_pkg::ACC_CSR_RESET});
		rdc("ctrl_b reset", acc_pkg::ACC_IDX_CTRL_B, {24'h0, acc_pkg::ACC_CTRLB_RESET});
		xfer(1'b1, acc_pkg::ACC_IDX_CTRL_B, 32'hff);
		rdc("ctrl_b mask", acc_pkg::ACC_IDX_CTRL_B, {24'h0, acc_pkg::ACC_CTRLB_MASK});
		rdc("unmapped", 8'h05, 32'h0);
		chk("hresp", 32'h0, {31'h0, hresp});
		foreach (rows[i])
		begin
			xfer(1'b1, acc_pkg::ACC_IDX_CTRL_B, {24'h0, rows[i].cb});
			xfer(1'b1, acc_pkg::ACC_IDX_CTRL_A, {24'h0, rows[i].ca});
			xfer(1'b1, acc_pkg::ACC_IDX_MUX, {24'h0, rows[i].mx});
			tick(3);
			chk("use pin", {31'h0, rows[i].pin}, {31'h0, pin});
			if (!rows[i].pin)
				chk("channel", {29'h0, rows[i].ch}, {29'h0, chan});
		end
		xfer(1'b1, acc_pkg::ACC_IDX_CTRL_B, 32'h0);
		xfer(1'b1, acc_pkg::ACC_IDX_IRQ_ENABLE, 32'h1);
		gie <= 1'b1;
		for (int k = 0; k < 4; k++)
		begin
			m = 2'(k);
			xfer(1'b1, acc_pkg::ACC_IDX_CSR, {24'h0, 6'h0c, m});
			xfer(1'b1, acc_pkg::ACC_IDX_IRQ_CLEAR, 32'h3);
			pos <= 12'h5dc;
			tick(5);
			rdc("rise", acc_pkg::ACC_IDX_CSR, {24'h0, 2'h0, 1'b1, m == 2'h0 || m == 2'h3, 2'h0, m});
			chk("irq rise", {31'h0, m == 2'h0 || m == 2'h3}, {31'h0, irq});
			xfer(1'b1, acc_pkg::ACC_IDX_CSR, {24'h0, 6'h04, m});
			pos <= 12'h1f4;
			tick(5);
			rdc("fall", acc_pkg::ACC_IDX_CSR, {24'h0, 3'h0, m == 2'h0 || m == 2'h2, 2'h0, m});
		end
		xfer(1'b1, acc_pkg::ACC_IDX_CSR, 32'h0);
		pos <= 12'h5dc;
		tick(5);
		xfer(1'b1, acc_pkg::ACC_IDX_CSR, 32'h0);
		rdc("flag kept", acc_pkg::ACC_IDX_CSR, 32'h30);
		xfer(1'b1, acc_pkg::ACC_IDX_CSR, 32'h08);
		tick(3);
		chk("req on", 32'h1, {31'h0, req});
		gie <= 1'b0;
		tick(3);
		chk("req gated", 32'h0, {31'h0, req});
		gie <= 1'b1;
		vtk <= 1'b1;
		tick(1);
		vtk <= 1'b0;
		tick(2);
		rdc("vector clear", acc_pkg::ACC_IDX_CSR, 32'h28);
		rdc("irq status", acc_pkg::ACC_IDX_IRQ_STATUS, 32'h3);
		xfer(1'b1, acc_pkg::ACC_IDX_IRQ_CLEAR, 32'h3);
		tick(3);
		chk("irq cleared", 32'h0, {31'h0, irq});
		xfer(1'b1, acc_pkg::ACC_IDX_CSR, 32'h04);
		tick(3);
		chk("capture on", 32'h1, {31'h0, cap});
		xfer(1'b1, acc_pkg::ACC_IDX_CSR, 32'h00);
		tick(3);
		chk("capture off", 32'h0, {31'h0, cap});
		pos <= 12'h1f4;
		xfer(1'b1, acc_pkg::ACC_IDX_CSR, 32'h40);
		tick(5);
		rdc("bandgap", acc_pkg::ACC_IDX_CSR, 32'h70);
		chk("bandgap out", 32'h1, {31'h0, bgs});
		xfer(1'b1, acc_pkg::ACC_IDX_CSR, 32'h80);
		tick(5);
		chk("power off", 32'h1, {31'h0, pwr});
		rdc("off result", acc_pkg::ACC_IDX_CSR, 32'h90);
		report_and_stop();
	end
	// Hang guard
	initial
	begin
		#200000;
		error_cnt++;
		report_and_stop();
	end
endmodule
`default_nettype wire
